// ### logic/clp_ctrl.sv
`timescale 1ns/1ps
`include "clp_map.svh"
module clp_ctrl #(
	parameter int FAIL_CYC = `CLP_FAIL_CYC, // Ticks missing before failure
	parameter int WAKE_CYC = `CLP_REG_WAKE_CYC // Regulator start-up cycles
) (
	input wire logic ref_clk, // 100 MHz system clock
	input wire logic reset_n, // Async reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [11:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error on unmapped address
	input wire logic [3:0] src_clk_pin, // Source clocks, indexed by clp_src_t
	input wire logic [3:0] src_ready_pin, // Oscillator ready flags
	input wire logic awu_ext_clk_pin, // External auto-wakeup clock
	input wire logic ext_irq_pin, // External interrupt level
	input wire logic int_irq, // Internal interrupt, same clock
	output clp_pkg::clp_gate_t gate, // Clock enables to core, memory, peripherals
	output logic master_clk_en, // Undivided master clock tick
	output logic regulator_on, // Main regulator enable
	output logic clock_output_pin, // Configurable clock output
	output logic irq // Level interrupt
);
	localparam logic [2:0] PSC_MAX = 3'h7; // Largest shift, divide by 128

	logic [3:0] src_tick; // Source tick pulses
	logic [3:0] src_ready; // Source ready levels
	logic [1:0] pin_level; // {awu clock, ext irq} levels
	logic [1:0] pin_rise; // {awu clock, ext irq} edges
	clp_pkg::clp_src_t src_req; // Requested source
	clp_pkg::clp_src_t active; // Active source
	logic master_tick; // Master clock tick
	logic sw_busy; // Switch in progress
	logic sw_done; // Switch completed
	logic [2:0] psc; // Prescaler shift
	logic mon_en; // Failure monitor enable
	logic [1:0] cco_sel; // Clock output rate
	logic cco_en; // Clock output enable
	logic awu_sel; // Auto-wakeup clock select
	logic [9:0] gate_off; // Per-unit clock stop bits
	logic [`CLP_NIRQ-1:0] irq_stat; // Sticky events
	logic [`CLP_NIRQ-1:0] irq_mask; // Interrupt mask
	logic [15:0] awu_period; // Auto-wakeup compare value
	logic [15:0] awu_cnt; // Auto-wakeup counter
	logic [7:0] psc_cnt; // Prescaler counter
	logic [31:0] fail_cnt; // Cycles since last external tick
	logic [31:0] wake_cnt; // Regulator start-up counter
	logic [2:0] cco_cnt; // Clock output counter
	clp_pkg::clp_lp_state_t lp; // Low-power state
	logic access; // APB access phase, first cycle
	logic wr_en; // Register write strobe
	logic ext_active; // External source drives master clock
	logic fail_evt; // External clock failure detected
	logic sys_tick; // Prescaled clock tick
	logic awu_tick; // Auto-wakeup clock tick
	logic awu_evt; // Auto-wakeup interval reached
	logic lp_enter; // Low-power command written
	logic [2:0] cco_half; // Clock output half period
	logic [7:0] psc_mask; // Prescaler terminal count

	// Known register offsets, shared by read and write paths
	function automatic logic addr_known(input logic [11:0] a);
		addr_known = (a == `CLP_OFF_CTRL) || (a == `CLP_OFF_GATE) || (a == `CLP_OFF_STATUS) ||
			(a == `CLP_OFF_IRQ_STAT) || (a == `CLP_OFF_IRQ_MASK) || (a == `CLP_OFF_LP_CMD) ||
			(a == `CLP_OFF_AWU_PERIOD);
	endfunction

	// Every pin from another clock domain crosses two flops before use; int_irq and the APB inputs are used directly
	clp_sync #(.W(4)) u_tick_sync (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.async_in(src_clk_pin),
		.level(),
		.rise(src_tick)
	);
	clp_sync #(.W(4)) u_ready_sync (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.async_in(src_ready_pin),
		.level(src_ready),
		.rise()
	);
	clp_sync #(.W(2)) u_pin_sync (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.async_in({awu_ext_clk_pin, ext_irq_pin}),
		.level(pin_level),
		.rise(pin_rise)
	);

	// Glitch-free source switch
	clp_switch u_switch (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.src_tick(src_tick),
		.src_ready(src_ready),
		.src_req(src_req),
		.force_fast(fail_evt),
		.active(active),
		.master_tick(master_tick),
		.busy(sw_busy),
		.done(sw_done)
	);

	// Second access cycle carries the answer, so pready is a flop
	assign access = psel && penable && !pready;
	assign wr_en = access && pwrite && addr_known(paddr);
	assign lp_enter = wr_en && (paddr == `CLP_OFF_LP_CMD) && (lp == clp_pkg::clp_lp_run);

	// APB answer
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0;
		end
		else
		begin
			pready <= access;
			pslverr <= access && !addr_known(paddr);
			prdata <= 32'h0;
			if (access && !pwrite)
			begin
				unique case (paddr)
					`CLP_OFF_CTRL: prdata <= {19'h0, awu_sel, cco_en, cco_sel, mon_en, 1'b0, psc, 2'h0, src_req};
					`CLP_OFF_GATE: prdata <= {22'h0, gate_off};
					`CLP_OFF_STATUS: prdata <= {19'h0, lp, src_ready, sw_busy, active};
					`CLP_OFF_IRQ_STAT: prdata <= {29'h0, irq_stat};
					`CLP_OFF_IRQ_MASK: prdata <= {29'h0, irq_mask};
					`CLP_OFF_AWU_PERIOD: prdata <= {16'h0, awu_period};
					default: prdata <= 32'h0;
				endcase
			end
		end
	end

	// Control registers; a failure overrides a write in the same cycle
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			src_req <= clp_pkg::clp_src_fast_rc;
			psc <= `CLP_PSC_RST;
			mon_en <= 1'b0;
			cco_sel <= 2'h0;
			cco_en <= 1'b0;
			awu_sel <= 1'b0;
		end
		else if (fail_evt)
		begin
			// Request parked on fast RC until software writes again
			src_req <= clp_pkg::clp_src_fast_rc;
			psc <= `CLP_PSC_RST;
		end
		else if (wr_en && paddr == `CLP_OFF_CTRL)
		begin
			src_req <= clp_pkg::clp_src_t'(pwdata[`CLP_CTRL_SRC]);
			psc <= pwdata[`CLP_CTRL_PSC];
			mon_en <= pwdata[`CLP_CTRL_MON_EN];
			cco_sel <= pwdata[`CLP_CTRL_CCO_SEL];
			cco_en <= pwdata[`CLP_CTRL_CCO_EN];
			awu_sel <= pwdata[`CLP_CTRL_AWU_SEL];
		end
	end

	// Gate, mask and wakeup period registers
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			gate_off <= 10'h0;
			irq_mask <= '0;
			awu_period <= `CLP_AWU_PERIOD_RST;
		end
		else if (wr_en)
		begin
			if (paddr == `CLP_OFF_GATE)
				gate_off <= pwdata[9:0];
			if (paddr == `CLP_OFF_IRQ_MASK)
				irq_mask <= pwdata[`CLP_NIRQ-1:0];
			if (paddr == `CLP_OFF_AWU_PERIOD)
				awu_period <= pwdata[15:0];
		end
	end

	// Sticky events, write one to clear; a new event beats the clear
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			irq_stat <= '0;
			irq <= 1'b0;
		end
		else
		begin
			if (wr_en && paddr == `CLP_OFF_IRQ_STAT)
				irq_stat <= (irq_stat & ~pwdata[`CLP_NIRQ-1:0]) | {awu_evt, sw_done, fail_evt};
			else
				irq_stat <= irq_stat | {awu_evt, sw_done, fail_evt};
			irq <= |(irq_stat & irq_mask);
		end
	end

	// Failure monitor watches ticks of the active external source
	assign ext_active = (active == clp_pkg::clp_src_ext_osc) || (active == clp_pkg::clp_src_ext_user);
	assign fail_evt = mon_en && ext_active && !sw_busy && (fail_cnt == 32'(FAIL_CYC));

	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
			fail_cnt <= 32'h0;
		else if (!ext_active || src_tick[active] || fail_evt)
			fail_cnt <= 32'h0;
		else if (fail_cnt != 32'(FAIL_CYC))
			fail_cnt <= fail_cnt + 32'h1;
	end

	// Prescaler: divide master ticks by two to the psc
	assign psc_mask = 8'(8'h1 << psc) - 8'h1;
	assign sys_tick = master_tick && (psc_cnt == psc_mask);

	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
			psc_cnt <= 8'h0;
		else if (psc_cnt > psc_mask)
			psc_cnt <= 8'h0; // Ratio lowered on the fly
		else if (master_tick)
			psc_cnt <= sys_tick ? 8'h0 : psc_cnt + 8'h1;
	end

	// Low-power sequencer
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
			lp <= clp_pkg::clp_lp_run;
		else
		begin
			unique case (lp)
				clp_pkg::clp_lp_run:
				begin
					if (lp_enter)
					begin
						unique case (pwdata[2:0])
							`CLP_CMD_WAIT: lp <= clp_pkg::clp_lp_wait;
							`CLP_CMD_AHALT_FAST: lp <= clp_pkg::clp_lp_ahalt_fast;
							`CLP_CMD_AHALT_SLOW: lp <= clp_pkg::clp_lp_ahalt_slow;
							`CLP_CMD_HALT: lp <= clp_pkg::clp_lp_halt;
							default: lp <= clp_pkg::clp_lp_run;
						endcase
					end
				end
				clp_pkg::clp_lp_wait:
					if (int_irq || pin_level[0])
						lp <= clp_pkg::clp_lp_run;
				clp_pkg::clp_lp_ahalt_fast:
					if (awu_evt || pin_level[0])
						lp <= clp_pkg::clp_lp_run;
				clp_pkg::clp_lp_ahalt_slow:
					if (awu_evt || pin_level[0])
						lp <= clp_pkg::clp_lp_wake;
				clp_pkg::clp_lp_halt:
					if (pin_level[0])
						lp <= clp_pkg::clp_lp_wake;
				clp_pkg::clp_lp_wake:
					if (wake_cnt == 32'(WAKE_CYC))
						lp <= clp_pkg::clp_lp_run;
				default:
					lp <= clp_pkg::clp_lp_run;
			endcase
		end
	end

	// Regulator start-up delay, the price of slow active-halt and halt
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			wake_cnt <= 32'h0;
			regulator_on <= 1'b1;
		end
		else
		begin
			wake_cnt <= (lp == clp_pkg::clp_lp_wake) ? wake_cnt + 32'h1 : 32'h0;
			regulator_on <= !(lp == clp_pkg::clp_lp_ahalt_slow || lp == clp_pkg::clp_lp_halt);
		end
	end

	// Auto-wakeup counter runs only in active-halt
	assign awu_tick = awu_sel ? pin_rise[1] : src_tick[clp_pkg::clp_src_slow_rc];
	assign awu_evt = awu_tick && (awu_cnt == awu_period) &&
		(lp == clp_pkg::clp_lp_ahalt_fast || lp == clp_pkg::clp_lp_ahalt_slow);

	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
			awu_cnt <= 16'h0;
		else if (!(lp == clp_pkg::clp_lp_ahalt_fast || lp == clp_pkg::clp_lp_ahalt_slow) || awu_evt)
			awu_cnt <= 16'h0;
		else if (awu_tick)
			awu_cnt <= awu_cnt + 16'h1;
	end

	// Clock enables; wait keeps peripherals, halt modes stop all gate bits while master_clk_en keeps running
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			gate <= '0;
			master_clk_en <= 1'b0;
		end
		else
		begin
			master_clk_en <= master_tick;
			gate.core <= sys_tick && (lp == clp_pkg::clp_lp_run) && !gate_off[`CLP_GATE_CORE];
			gate.mem <= sys_tick && (lp == clp_pkg::clp_lp_run || lp == clp_pkg::clp_lp_wait) &&
				!gate_off[`CLP_GATE_MEM];
			gate.periph <= {`CLP_NPER{sys_tick && (lp == clp_pkg::clp_lp_run || lp == clp_pkg::clp_lp_wait)}} &
				~gate_off[`CLP_GATE_PERIPH];
		end
	end

	// Clock output derived from fast RC ticks
	always_comb
	begin
		unique case (cco_sel)
			2'h0: cco_half = `CLP_CCO_HALF_8M;
			2'h1: cco_half = `CLP_CCO_HALF_4M;
			default: cco_half = `CLP_CCO_HALF_1M;
		endcase
	end

	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			cco_cnt <= 3'h0;
			clock_output_pin <= 1'b0;
		end
		else if (!cco_en)
		begin
			cco_cnt <= 3'h0;
			clock_output_pin <= 1'b0;
		end
		else if (src_tick[clp_pkg::clp_src_fast_rc])
		begin
			if (cco_cnt >= cco_half)
			begin
				cco_cnt <= 3'h0;
				clock_output_pin <= !clock_output_pin;
			end
			else
				cco_cnt <= cco_cnt + 3'h1;
		end
	end
endmodule // clp_ctrl

// ### logic/clp_map.svh
`ifndef CLP_MAP_SVH
`define CLP_MAP_SVH
// Register byte offsets (APB, one word each)
`define CLP_OFF_CTRL 12'h000
`define CLP_OFF_GATE 12'h004
`define CLP_OFF_STATUS 12'h008
`define CLP_OFF_IRQ_STAT 12'h00c
`define CLP_OFF_IRQ_MASK 12'h010
`define CLP_OFF_LP_CMD 12'h014
`define CLP_OFF_AWU_PERIOD 12'h018
// Control register fields
`define CLP_CTRL_SRC 1:0
`define CLP_CTRL_PSC 6:4
`define CLP_CTRL_MON_EN 8
`define CLP_CTRL_CCO_SEL 10:9
`define CLP_CTRL_CCO_EN 11
`define CLP_CTRL_AWU_SEL 12
// Gate register fields, a one stops that clock
`define CLP_GATE_CORE 0
`define CLP_GATE_MEM 1
`define CLP_GATE_PERIPH 9:2
// Interrupt status bits
`define CLP_IRQ_FAIL 0
`define CLP_IRQ_SWITCH 1
`define CLP_IRQ_AWU 2
`define CLP_NIRQ 3
`define CLP_NPER 8
// Low-power command codes
`define CLP_CMD_WAIT 3'h1
`define CLP_CMD_AHALT_FAST 3'h2
`define CLP_CMD_AHALT_SLOW 3'h3
`define CLP_CMD_HALT 3'h4
// Reset values: fast RC divided by eight
`define CLP_PSC_RST 3'h3
`define CLP_AWU_PERIOD_RST 16'h00ff
// Clock output half periods in fast RC ticks: 8, 4, 1 MHz
`define CLP_CCO_HALF_8M 3'h0
`define CLP_CCO_HALF_4M 3'h1
`define CLP_CCO_HALF_1M 3'h7
// Timing
`define CLP_CLK_PERIOD_NS 10
`define CLP_FAIL_NS 2000
`define CLP_FAIL_CYC ((`CLP_FAIL_NS + `CLP_CLK_PERIOD_NS - 1) / `CLP_CLK_PERIOD_NS)
`define CLP_REG_WAKE_NS 5000
`define CLP_REG_WAKE_CYC ((`CLP_REG_WAKE_NS + `CLP_CLK_PERIOD_NS - 1) / `CLP_CLK_PERIOD_NS)
`endif

// ### logic/clp_pkg.sv
`include "clp_map.svh"
package clp_pkg;
	// Master clock sources, index into the source tick vectors
	typedef enum logic [1:0] {
		clp_src_fast_rc = 2'h0,
		clp_src_slow_rc = 2'h1,
		clp_src_ext_osc = 2'h2,
		clp_src_ext_user = 2'h3
	} clp_src_t;
	// Source switch sequencer
	typedef enum logic [2:0] {
		clp_sw_idle = 3'b001,
		clp_sw_wait_old = 3'b010,
		clp_sw_wait_new = 3'b100
	} clp_sw_state_t;
	// Low-power mode sequencer
	typedef enum logic [5:0] {
		clp_lp_run = 6'b000001,
		clp_lp_wait = 6'b000010,
		clp_lp_ahalt_fast = 6'b000100,
		clp_lp_ahalt_slow = 6'b001000,
		clp_lp_halt = 6'b010000,
		clp_lp_wake = 6'b100000
	} clp_lp_state_t;
	// Distributed clock enables
	typedef struct packed {
		logic core;
		logic mem;
		logic [`CLP_NPER-1:0] periph;
	} clp_gate_t;
endpackage

// ### logic/clp_switch.sv
`timescale 1ns/1ps
module clp_switch (
	input wire logic ref_clk, // System clock
	input wire logic reset_n, // Async reset, active low
	input wire logic [3:0] src_tick, // Synchronised source ticks
	input wire logic [3:0] src_ready, // Synchronised oscillator ready
	input wire clp_pkg::clp_src_t src_req, // Requested source
	input wire logic force_fast, // Failure fallback pulse
	output clp_pkg::clp_src_t active, // Source now driving master clock
	output logic master_tick, // Master clock tick
	output logic busy, // Switch in progress
	output logic done // Pulse when a switch completes
);
	clp_pkg::clp_sw_state_t state; // Sequencer state
	clp_pkg::clp_src_t target; // Source being switched to

	// Sequencer: finish old phase, then align to a full new phase
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			state <= clp_pkg::clp_sw_idle;
			target <= clp_pkg::clp_src_fast_rc;
			active <= clp_pkg::clp_src_fast_rc;
			done <= 1'b0;
		end
		else
		begin
			done <= 1'b0;
			unique case (state)
				clp_pkg::clp_sw_idle:
				begin
					// Dead source has no phase left to finish
					if (force_fast)
					begin
						target <= clp_pkg::clp_src_fast_rc;
						state <= clp_pkg::clp_sw_wait_new;
					end
					else if (src_req != active && src_ready[src_req])
					begin
						target <= src_req;
						state <= clp_pkg::clp_sw_wait_old;
					end
				end
				clp_pkg::clp_sw_wait_old:
				begin
					// Old source keeps running until its phase ends
					if (force_fast)
					begin
						target <= clp_pkg::clp_src_fast_rc;
						state <= clp_pkg::clp_sw_wait_new;
					end
					else if (src_tick[active])
						state <= clp_pkg::clp_sw_wait_new;
				end
				clp_pkg::clp_sw_wait_new:
				begin
					// First new tick is swallowed so no phase is short
					if (src_tick[target] && src_ready[target])
					begin
						active <= target;
						done <= 1'b1;
						state <= clp_pkg::clp_sw_idle;
					end
				end
			endcase
		end
	end

	// Ticks gated off while waiting for the new source
	assign master_tick = (state != clp_pkg::clp_sw_wait_new) && src_tick[active];
	assign busy = (state != clp_pkg::clp_sw_idle);
endmodule // clp_switch

// ### logic/clp_sync.sv
`timescale 1ns/1ps
module clp_sync #(
	parameter int W = 1
) (
	input wire logic ref_clk, // System clock
	input wire logic reset_n, // Async reset, active low
	input wire logic [W-1:0] async_in, // Pins from another domain
	output logic [W-1:0] level, // Synchronised level
	output logic [W-1:0] rise // One-cycle pulse on rising edge
);
	logic [W-1:0] meta; // First stage, read only by second
	logic [W-1:0] stage2; // Second stage
	logic [W-1:0] stage3; // Edge history

	// Two-flop synchroniser plus history for edge detection
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			meta <= '0;
			stage2 <= '0;
			stage3 <= '0;
		end
		else
		begin
			meta <= async_in;
			stage2 <= meta;
			stage3 <= stage2;
		end
	end

	assign level = stage2;
	assign rise = stage2 & ~stage3;
endmodule // clp_sync

// ### testbench/clp_ctrl_sva.sv
`timescale 1ns/1ps
module clp_ctrl_chk #(
	parameter int FAIL_CYC = 200, // Missing ticks before failure
	parameter int WAKE_CYC = 500 // Regulator start-up cycles
) (
	input wire logic ref_clk, // Clock
	input wire logic reset_n, // Reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [11:0] paddr, // APB address
	input wire logic [31:0] pwdata, // APB write data
	input wire logic [31:0] prdata, // APB read data
	input wire logic pready, // APB ready
	input wire logic pslverr, // APB error
	input wire logic [3:0] src_clk_pin, // Source clocks
	input wire logic [3:0] src_ready_pin, // Oscillator ready
	input wire logic awu_ext_clk_pin, // Wake-up clock
	input wire logic ext_irq_pin, // External interrupt
	input wire logic int_irq, // Internal interrupt
	input wire clp_pkg::clp_gate_t gate, // Clock enables
	input wire logic master_clk_en, // Master tick
	input wire logic regulator_on, // Regulator enable
	input wire logic clock_output_pin, // Clock output
	input wire logic irq // Interrupt
);
	// One domain, so one clock and one reset for all
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!reset_n);
	a_ready_after: assert property (psel && penable && !pready |=> pready)
		else $error("ready missing after access");
	a_ready_single: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	a_ready_idle: assert property (!(psel && penable) |=> !pready)
		else $error("ready without access");
	a_err_ready: assert property (pslverr |-> pready)
		else $error("error without ready");
	a_err_decode: assert property (psel && penable && !pready && paddr > 12'h018 |=> pslverr)
		else $error("unmapped access not refused");
	a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
		else $error("read data outside answer");
	a_stop_gates: assert property (!regulator_on |-> gate == '0)
		else $error("clock running with regulator off");
	a_gate_pulse: assert property (gate.core |=> !gate.core)
		else $error("core enable wider than one cycle");
	// Short master phases would show as ticks closer than a source period
	a_master_gap: assert property (master_clk_en |=> !master_clk_en [*4])
		else $error("master ticks too close");
	a_reg_reset: assert property ($rose(reset_n) |-> regulator_on)
		else $error("regulator off after reset");
	c_refused: cover property (pslverr);
	c_irq: cover property ($rose(irq));
	c_reg_off: cover property ($fell(regulator_on));
endmodule // clp_ctrl_chk
bind clp_ctrl clp_ctrl_chk #(.FAIL_CYC(FAIL_CYC), .WAKE_CYC(WAKE_CYC)) chk (.ref_clk(ref_clk), .reset_n(reset_n),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .src_clk_pin(src_clk_pin), .src_ready_pin(src_ready_pin),
	.awu_ext_clk_pin(awu_ext_clk_pin), .ext_irq_pin(ext_irq_pin), .int_irq(int_irq), .gate(gate),
	.master_clk_en(master_clk_en), .regulator_on(regulator_on), .clock_output_pin(clock_output_pin), .irq(irq));

// ### testbench/clp_ctrl_test.sv
`timescale 1ns/1ps
`include "clp_map.svh"
module clp_ctrl_test;
	logic ref_clk, reset_n, psel, penable, pwrite, awu_ext_clk_pin, ext_irq_pin, int_irq, ext_run;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdata, r;
	logic pready, pslverr, master_clk_en, regulator_on, clock_output_pin, irq;
	logic [3:0] src_clk_pin, src_ready_pin;
	clp_pkg::clp_gate_t gate;
	int fails, cmp_count, div_cnt, n, s;
	int pc[10]; // Pulse counts per gate bit
	integer seed = 32'h80b2237a;
	logic [31:0] exp_d[$], exp_m[$]; // Expected read data and mask
	logic exp_e[$]; // Expected error
	clp_ctrl #(.FAIL_CYC(20), .WAKE_CYC(10)) DUT (.ref_clk(ref_clk), .reset_n(reset_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .src_clk_pin(src_clk_pin), .src_ready_pin(src_ready_pin),
		.awu_ext_clk_pin(awu_ext_clk_pin), .ext_irq_pin(ext_irq_pin), .int_irq(int_irq), .gate(gate),
		.master_clk_en(master_clk_en), .regulator_on(regulator_on), .clock_output_pin(clock_output_pin), .irq(irq));
	initial
	begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	// Sources: fast RC 6 cycles, slow RC 80, ext osc 8, ext user 10
	always @(posedge ref_clk)
	begin
		div_cnt <= div_cnt + 1;
		src_clk_pin[0] <= (div_cnt % 6) < 3;
		src_clk_pin[1] <= (div_cnt % 80) < 40;
		src_clk_pin[2] <= ext_run && (div_cnt % 8) < 4;
		src_clk_pin[3] <= (div_cnt % 10) < 5;
		awu_ext_clk_pin <= (div_cnt % 50) < 25;
	end
	task report_and_stop;
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task chk32(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			fails++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task chk1(input logic got, input logic exp);
		chk32({31'h0, got}, {31'h0, exp});
	endtask
	task tmo;
		chk1(1'b0, 1'b1);
		report_and_stop;
	endtask
	// One APB transfer; the expectation is noted for the monitor
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] m, input logic [31:0] e);
		int k;
		k = 0;
		@(posedge ref_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		exp_d.push_back(w ? 32'h0 : e);
		exp_m.push_back(w ? 32'h0 : m);
		exp_e.push_back(a > 12'h018);
		@(posedge ref_clk);
		penable <= 1'b1;
		@(posedge ref_clk);
		while (pready !== 1'b1 && k < 20)
		begin
			@(posedge ref_clk);
			k++;
		end
		if (k == 20)
			tmo;
		rdata = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 32'h0, 32'h0);
	endtask
	task rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
		apb(1'b0, a, 32'h0, m, e);
	endtask
	// Bounded poll of a field until it shows the value
	task poll(input logic [11:0] a, input logic [31:0] m, input logic [31:0] v);
		int k;
		k = 0;
		rd(a, 32'h0, 32'h0);
		while ((rdata & m) !== v && k < 300)
		begin
			rd(a, 32'h0, 32'h0);
			k++;
		end
		if (k == 300)
			tmo;
	endtask
	// Count enable pulses of each gate bit over a window
	task pulses(input int cyc);
		for (int i = 0; i < 10; i++)
			pc[i] = 0;
		repeat (cyc)
		begin
			@(posedge ref_clk);
			for (int i = 0; i < 10; i++)
				pc[i] += gate[i];
		end
	endtask
	// Master ticks between two prescaled ticks
	task gap(output int c);
		int t;
		c = 0;
		t = 0;
		while (gate.core !== 1'b1 && t < 2000)
		begin
			@(posedge ref_clk);
			t++;
		end
		@(posedge ref_clk);
		c = master_clk_en;
		while (gate.core !== 1'b1 && t < 2000)
		begin
			@(posedge ref_clk);
			c += master_clk_en;
			t++;
		end
		if (t >= 2000)
			tmo;
	endtask
	// Cycles between toggles of the clock output, after two settling toggles
	task half(output int c);
		logic v;
		c = 0;
		repeat (3)
		begin
			c = 0;
			v = clock_output_pin;
			while (clock_output_pin === v && c < 500)
			begin
				@(posedge ref_clk);
				c++;
			end
			if (c >= 500)
				tmo;
		end
	endtask
	// Monitor: each answer against the oldest note
	always @(posedge ref_clk)
	begin
		if (reset_n && pready === 1'b1)
		begin
			if (exp_d.size() == 0)
				chk1(1'b1, 1'b0);
			else
			begin
				chk32(prdata & exp_m.pop_front(), exp_d.pop_front());
				chk1(pslverr, exp_e.pop_front());
			end
		end
	end
	initial
	begin
		{psel, penable, pwrite, paddr, pwdata, ext_irq_pin, int_irq, reset_n} = '0;
		src_ready_pin = 4'b1011; // External oscillator not ready yet
		ext_run = 1'b1;
		repeat (4) @(posedge ref_clk);
		reset_n <= 1'b1;
		rd(`CLP_OFF_CTRL, 32'hffffffff, 32'h30);
		rd(`CLP_OFF_STATUS, 32'h1f87, 32'h80);
		rd(`CLP_OFF_GATE, 32'hffffffff, 32'h0);
		rd(`CLP_OFF_IRQ_MASK, 32'hffffffff, 32'h0);
		rd(`CLP_OFF_AWU_PERIOD, 32'hffffffff, 32'hff);
		rd(12'h01c, 32'hffffffff, 32'h0);
		wr(`CLP_OFF_STATUS, 32'hffffffff);
		rd(`CLP_OFF_STATUS, 32'h87, 32'h80);
		// Every ratio, master ticks per prescaled tick
		for (s = 0; s < 8; s++)
		begin
			wr(`CLP_OFF_CTRL, s << 4);
			gap(n);
			gap(n);
			chk32(n, 32'h1 << s);
		end
		// Random stop pattern, compared bit by bit
		wr(`CLP_OFF_CTRL, 32'h0);
		r = $random(seed) & 32'h3ff;
		wr(`CLP_OFF_GATE, r);
		pulses(120);
		r = {22'h0, r[0], r[1], r[9:2]};
		for (s = 0; s < 10; s++)
			chk1(pc[s] != 0, !r[s]);
		wr(`CLP_OFF_GATE, 32'h0);
		// Switch waits for the new source to be ready
		wr(`CLP_OFF_IRQ_MASK, 32'h2);
		wr(`CLP_OFF_CTRL, 32'h2);
		repeat (100) @(posedge ref_clk);
		rd(`CLP_OFF_STATUS, 32'h3, 32'h0);
		src_ready_pin <= 4'hf;
		poll(`CLP_OFF_STATUS, 32'h7, 32'h2);
		rd(`CLP_OFF_IRQ_STAT, 32'h7, 32'h2);
		chk1(irq, 1'b1);
		wr(`CLP_OFF_IRQ_MASK, 32'h0);
		repeat (3) @(posedge ref_clk);
		chk1(irq, 1'b0);
		wr(`CLP_OFF_IRQ_STAT, 32'h2);
		rd(`CLP_OFF_IRQ_STAT, 32'h7, 32'h0);
		for (s = 3; s >= 0; s--)
		begin
			wr(`CLP_OFF_CTRL, s);
			poll(`CLP_OFF_STATUS, 32'h7, s);
		end
		// External oscillator stops under the monitor
		wr(`CLP_OFF_IRQ_MASK, 32'h1);
		wr(`CLP_OFF_CTRL, 32'h102);
		poll(`CLP_OFF_STATUS, 32'h7, 32'h2);
		ext_run <= 1'b0;
		poll(`CLP_OFF_STATUS, 32'h7, 32'h0);
		rd(`CLP_OFF_IRQ_STAT, 32'h1, 32'h1);
		chk1(irq, 1'b1);
		rd(`CLP_OFF_CTRL, 32'h73, 32'h30);
		ext_run <= 1'b1;
		repeat (100) @(posedge ref_clk);
		rd(`CLP_OFF_STATUS, 32'h3, 32'h0);
		wr(`CLP_OFF_IRQ_STAT, 32'h1);
		wr(`CLP_OFF_IRQ_MASK, 32'h0);
		// Clock output half periods: 1, 2, 8, 8 fast RC ticks
		for (s = 0; s < 4; s++)
		begin
			wr(`CLP_OFF_CTRL, 32'h800 | (s << 9));
			half(n);
			chk32(n, s == 0 ? 6 : s == 1 ? 12 : 48);
		end
		// Wait: core still, peripherals run, internal interrupt resumes
		wr(`CLP_OFF_LP_CMD, `CLP_CMD_WAIT);
		rd(`CLP_OFF_STATUS, 32'h1f80, 32'h100);
		pulses(100);
		chk1(pc[9] == 0 && pc[0] != 0, 1'b1);
		int_irq <= 1'b1;
		poll(`CLP_OFF_STATUS, 32'h1f80, 32'h80);
		int_irq <= 1'b0;
		// Fast active halt ends on the wake-up event
		wr(`CLP_OFF_AWU_PERIOD, 32'h2);
		wr(`CLP_OFF_LP_CMD, `CLP_CMD_AHALT_FAST);
		rd(`CLP_OFF_STATUS, 32'h1f80, 32'h200);
		chk1(regulator_on, 1'b1);
		poll(`CLP_OFF_STATUS, 32'h1f80, 32'h80);
		rd(`CLP_OFF_IRQ_STAT, 32'h4, 32'h4);
		wr(`CLP_OFF_IRQ_STAT, 32'h4);
		// Slow active halt, wake-up counted on the external pin
		wr(`CLP_OFF_CTRL, 32'h1000);
		wr(`CLP_OFF_LP_CMD, `CLP_CMD_AHALT_SLOW);
		repeat (3) @(posedge ref_clk);
		chk1(regulator_on, 1'b0);
		poll(`CLP_OFF_STATUS, 32'h1f80, 32'h80);
		chk1(regulator_on, 1'b1);
		// Halt ignores the wake-up counter, only the external pin wakes
		wr(`CLP_OFF_LP_CMD, `CLP_CMD_HALT);
		repeat (600) @(posedge ref_clk);
		rd(`CLP_OFF_STATUS, 32'h1f80, 32'h800);
		chk1(regulator_on, 1'b0);
		ext_irq_pin <= 1'b1;
		poll(`CLP_OFF_STATUS, 32'h1f80, 32'h80);
		ext_irq_pin <= 1'b0;
		report_and_stop;
	end
endmodule // clp_ctrl_test
